// ===== uls_pkg.sv
// Purpose: Constants for the full-speed line-state detector
// Assumes: 250 MHz core clock, 12 Mb/s line rate
// Notes:   Times kept in their own units, cycle counts derived
package uls_pkg;

    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned BIT_RATE_HZ     = 12_000_000;
    localparam int unsigned OVERSAMPLE      = 4;
    // Sample enable period in core cycles (rounded down)
    localparam int unsigned SAMPLE_DIV      = CLK_HZ / (BIT_RATE_HZ * OVERSAMPLE);
    // Reset detection: 2.5 us least time
    localparam int unsigned RESET_TIME_NS   = 2500;
    // Counted in real sample periods, rounded up, so never under 2.5 us
    localparam int unsigned RESET_SAMPLES   =
        (RESET_TIME_NS * (CLK_HZ / 1_000_000) / SAMPLE_DIV + 999) / 1000;
    // Approximate one bit time: accept three of four samples
    localparam int unsigned EOP_MIN_SAMPLES = OVERSAMPLE - 1;
    localparam int unsigned J_MIN_SAMPLES   = OVERSAMPLE - 1;

    typedef enum logic [1:0] {
        ULS_SE0 = 2'h0,
        ULS_J   = 2'h1,
        ULS_K   = 2'h2,
        ULS_SE1 = 2'h3
    } uls_line_t;

    typedef enum {
        ULS_ST_IDLE,
        ULS_ST_PACKET,
        ULS_ST_SE0,
        ULS_ST_EOP_J
    } uls_state_t;

endpackage

// ===== uls_line_state_detector.sv
// Purpose: Decode idle, K, SE0, start/end of packet and bus reset on D+/D-
// Assumes: Raw pins asynchronous to core_clk_in; only the line pins are watched
// Notes:   Outputs are registered; sop and eop are one-cycle pulses, bus reset is a level held while SE0 lasts
//
// Contract
// RULE1: Flag start of packet on idle to K
// RULE2: End of packet is SE0 then J
// RULE3: Widths measured approximately in full-speed bits
// RULE4: SE0 for 2.5 us or longer is reset
// RULE5: D+ high, D- low decodes idle J
// RULE6: Bit durations derived from 12 Mb/s
// RULE7: Synchronise lines, sample at four per bit
`timescale 1ns/1ps
module uls_line_state_detector
    import uls_pkg::*;
#(
    parameter int unsigned RESET_COUNT = RESET_SAMPLES
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_b_in,
    // Bus data lines
    input  wire logic dp_in,
    input  wire logic dm_in,
    // Line state
    output logic [1:0] line_state_out,
    output logic       idle_out,
    output logic       se0_out,
    // Events
    output logic       sop_out,
    output logic       eop_out,
    output logic       bus_reset_out
);

    localparam int CW = 16;
    localparam int DW = $clog2(SAMPLE_DIV + 1);

    typedef struct packed {
        logic [2:0]    dp_sync;
        logic [2:0]    dm_sync;
        logic [DW-1:0] div;
        logic          tick;
        uls_line_t     line;
        uls_state_t    st;
        logic [CW-1:0] cnt;
        logic [CW-1:0] se0_cnt;
        logic          in_reset;
        logic [1:0]    line_o;
        logic          idle_o;
        logic          se0_o;
        logic          sop;
        logic          eop;
        logic          rst_o;
    } uls_regs_t;

    uls_regs_t r_q;
    uls_regs_t r_d;
    uls_line_t samp;

    // ==================================================
    // Next state
    always_comb begin
        r_d     = r_q;
        r_d.sop = 1'b0;
        r_d.eop = 1'b0;
        // Three-stage synchroniser, stages two and three must agree
        r_d.dp_sync = {r_q.dp_sync[1:0], dp_in}; // [RULE7]
        r_d.dm_sync = {r_q.dm_sync[1:0], dm_in}; // [RULE7]
        // Four samples per bit time from the core clock
        r_d.tick = 1'b0;
        if (r_q.div == DW'(SAMPLE_DIV - 1)) begin // [RULE6] [RULE7]
            r_d.div  = '0;
            r_d.tick = 1'b1;
        end else begin
            r_d.div = r_q.div + DW'(1);
        end
        samp = r_q.line;
        if ((r_q.dp_sync[2] == r_q.dp_sync[1]) && (r_q.dm_sync[2] == r_q.dm_sync[1])) begin
            samp = uls_line_t'({r_q.dm_sync[2], r_q.dp_sync[2]}); // [RULE5]
        end
        if (r_q.tick) begin
            r_d.line = samp;
            // Reset: continuous SE0 count, held until SE0 ends
            if (samp == ULS_SE0) begin
                if (r_q.se0_cnt != CW'(RESET_COUNT)) begin
                    r_d.se0_cnt = r_q.se0_cnt + CW'(1);
                end
                if (r_q.se0_cnt == CW'(RESET_COUNT - 1)) begin // [RULE4]
                    r_d.in_reset = 1'b1;
                end
            end else begin
                r_d.se0_cnt  = '0;
                r_d.in_reset = 1'b0;
            end
            case (r_q.st)
                ULS_ST_IDLE: begin
                    if (samp == ULS_K && r_q.line == ULS_J) begin // [RULE1]
                        r_d.sop = 1'b1;
                        r_d.st  = ULS_ST_PACKET;
                    end
                end
                ULS_ST_PACKET: begin
                    if (samp == ULS_SE0) begin
                        r_d.st  = ULS_ST_SE0;
                        r_d.cnt = CW'(1);
                    end
                end
                ULS_ST_SE0: begin
                    if (samp == ULS_SE0) begin
                        r_d.cnt = r_q.cnt + CW'(1);
                    end else if (samp == ULS_J &&
                                 r_q.cnt >= CW'(EOP_MIN_SAMPLES)) begin // [RULE2] [RULE3]
                        r_d.st  = ULS_ST_EOP_J;
                        r_d.cnt = CW'(1);
                    end else begin
                        r_d.st = ULS_ST_PACKET;
                    end
                end
                ULS_ST_EOP_J: begin
                    if (samp == ULS_J) begin
                        r_d.cnt = r_q.cnt + CW'(1);
                        if (r_q.cnt == CW'(J_MIN_SAMPLES - 1)) begin // [RULE2] [RULE3]
                            r_d.eop = 1'b1;
                            r_d.st  = ULS_ST_IDLE;
                        end
                    end else begin
                        r_d.st = ULS_ST_PACKET;
                    end
                end
                default: r_d.st = ULS_ST_IDLE;
            endcase
            // Reset overrides any packet in progress
            if (r_d.in_reset) begin
                r_d.st = ULS_ST_IDLE;
            end
        end
        r_d.line_o = r_d.line;
        r_d.idle_o = (r_d.line == ULS_J); // [RULE5]
        r_d.se0_o  = (r_d.line == ULS_SE0);
        r_d.rst_o  = r_d.in_reset;
    end

    // ==================================================
    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r_q         <= '0;
            // Synchroniser starts at the idle J level, no false edge
            r_q.dp_sync <= '1;
            r_q.line    <= ULS_J;
            r_q.line_o  <= ULS_J;
            r_q.idle_o  <= 1'b1;
            r_q.st      <= ULS_ST_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign line_state_out = r_q.line_o;
    assign idle_out       = r_q.idle_o;
    assign se0_out        = r_q.se0_o;
    assign sop_out        = r_q.sop;
    assign eop_out        = r_q.eop;
    assign bus_reset_out  = r_q.rst_o;

    // ==================================================
    // Assertions
    property p_sop_from_idle; // [RULE1]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        $rose(sop_out) |-> r_q.line == ULS_K && $past(r_q.line) == ULS_J;
    endproperty
    a_sop_from_idle: assert property (p_sop_from_idle) else $error("sop without K"); // [RULE1]

    property p_eop_after_j; // [RULE2]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        eop_out |-> line_state_out == ULS_J;
    endproperty
    a_eop_after_j: assert property (p_eop_after_j) else $error("eop not in J"); // [RULE2]

    // Pulse only leaves the J phase that followed SE0
    sequence s_j_after_se0;
        $past(r_q.st) == ULS_ST_EOP_J && r_q.st == ULS_ST_IDLE;
    endsequence

    property p_eop_after_se0; // [RULE2]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        eop_out |-> s_j_after_se0;
    endproperty
    a_eop_after_se0: assert property (p_eop_after_se0) else $error("eop order"); // [RULE2]

    property p_eop_pulse; // [RULE3]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        eop_out |=> !eop_out;
    endproperty
    a_eop_pulse: assert property (p_eop_pulse) else $error("eop too long"); // [RULE3]

    property p_reset_needs_se0; // [RULE4]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        $rose(bus_reset_out) |-> se0_out && r_q.se0_cnt == CW'(RESET_COUNT);
    endproperty
    a_reset_needs_se0: assert property (p_reset_needs_se0) else $error("reset early"); // [RULE4]

    property p_reset_ends; // [RULE4]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        bus_reset_out && !se0_out |-> 1'b0;
    endproperty
    a_reset_ends: assert property (p_reset_ends) else $error("reset without SE0"); // [RULE4]

    property p_idle_is_j; // [RULE5]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        idle_out == (line_state_out == ULS_J);
    endproperty
    a_idle_is_j: assert property (p_idle_is_j) else $error("idle decode wrong"); // [RULE5]

    // Four quiet cycles, then the next sample enable
    sequence s_tick_gap;
        !r_q.tick [*4] ##1 r_q.tick;
    endsequence

    property p_tick_period; // [RULE6]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        r_q.tick |=> s_tick_gap;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("sample rate wrong"); // [RULE6]

    property p_line_on_tick; // [RULE7]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !$past(r_q.tick) |-> $stable(r_q.line);
    endproperty
    a_line_on_tick: assert property (p_line_on_tick) else $error("line off tick"); // [RULE7]

endmodule

// ===== uls_host_model.sv
// Purpose: Host port model driving the full-speed data lines
// Assumes: Levels change only at rising edges of clk_in
// Notes:   Reset hold shortened to suit the shortened detector count
`timescale 1ns/1ps
module uls_host_model (
    // Clock
    input  wire logic clk_in,
    // Data lines
    output logic      dp_out,
    output logic      dm_out
);
    initial begin
        dp_out = 1'b1;
        dm_out = 1'b0;
    end
    // Hold {dm,dp} for a number of clocks
    task automatic drive(input logic [1:0] st, input int clks);
        @(posedge clk_in);
        dp_out <= st[0];
        dm_out <= st[1];
        repeat (clks - 1) @(posedge clk_in);
    endtask
    // SE0 then about one and a half bit times (31 clocks) of J
    task automatic end_packet(input int se0_clks);
        drive(2'h0, se0_clks);
        drive(2'h1, 21 + 10);
    endtask
    // Both lines low long enough for the detector
    task automatic bus_reset(input int clks);
        drive(2'h0, clks);
    endtask
endmodule

// ===== uls_line_state_detector_tb_top.sv
// Purpose: Self-checking bench for the line-state detector
// Assumes: Host model drives the lines, 21 clocks per bit
// Notes:   Reset count shortened to 16 samples, above a two-bit SE0
`timescale 1ns/1ps
module uls_line_state_detector_tb_top;
    import uls_pkg::*;
    localparam int unsigned RST_N = 16;
    localparam int          BIT   = 21;
    logic       core_clk_in = 1'b0;
    logic       rst_b_in    = 1'b0;
    wire  logic dp;
    wire  logic dm;
    logic [1:0] line_state;
    logic       idle;
    logic       se0;
    logic       sop;
    logic       eop;
    logic       bus_reset;
    int         mismatches  = 0;
    int         checks      = 0;
    int         cycles      = 0;
    int         sop_n       = 0;
    int         eop_n       = 0;
    uls_host_model i_uls_host_model (.clk_in(core_clk_in), .dp_out(dp), .dm_out(dm));
    uls_line_state_detector #(.RESET_COUNT(RST_N)) i_uls_line_state_detector (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .dp_in(dp), .dm_in(dm),
        .line_state_out(line_state), .idle_out(idle), .se0_out(se0),
        .sop_out(sop), .eop_out(eop), .bus_reset_out(bus_reset));
    initial forever #2 core_clk_in = ~core_clk_in;
    // ==========
    // Pulse counting and timeout
    always @(posedge core_clk_in) begin
        cycles++;
        if (sop === 1'b1) sop_n++;
        if (eop === 1'b1) eop_n++;
        if (cycles == 2000) begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        #1;
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset();
        chk({line_state, idle, se0}, 4'h6);
        chk({1'b0, sop, eop, bus_reset}, 4'h0);
    endtask
    task automatic t_sop();
        i_uls_host_model.drive(2'h1, BIT);
        sop_n = 0;
        i_uls_host_model.drive(2'h2, 3);
        chk({2'h0, line_state}, 4'h1);
        i_uls_host_model.drive(2'h2, 2 * BIT);
        chk({2'h0, line_state}, 4'h2);
        chk(sop_n[3:0], 4'h1);
    endtask
    task automatic t_eop();
        eop_n = 0;
        i_uls_host_model.drive(2'h0, 4);
        i_uls_host_model.drive(2'h2, BIT);
        chk(eop_n[3:0], 4'h0);
        i_uls_host_model.end_packet(2 * BIT);
        chk(eop_n[3:0], 4'h1);
        chk({idle, se0, 2'h0}, 4'h8);
        i_uls_host_model.drive(2'h2, BIT);
        chk(sop_n[3:0], 4'h2);
        i_uls_host_model.end_packet(BIT);
        chk(eop_n[3:0], 4'h2);
    endtask
    task automatic t_bus_reset();
        i_uls_host_model.drive(2'h0, 25);
        chk({se0, bus_reset, 2'h0}, 4'h8);
        i_uls_host_model.bus_reset(int'(RST_N * SAMPLE_DIV) + 15);
        chk({se0, bus_reset, 2'h0}, 4'hc);
        i_uls_host_model.drive(2'h1, 15);
        chk({idle, bus_reset, line_state}, 4'h9);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_sop();
        t_eop();
        t_bus_reset();
        results();
    end
endmodule
